// ==== design/djc_top.sv ====
// io line four function, limit and home switch evaluation, manual move control
`timescale 1ns/10ps
module djc_top #(
	parameter logic [15:0] LINE_FUNC_RESET = 16'h0001
) (
	// clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_reset_n,
	// parameter access
	input  wire djc_pkg::djc_par_req_t i_par_req,
	output logic                       o_par_ack,
	output logic                       o_par_err,
	output logic [15:0]                o_par_rdata,
	// local lines
	input  wire logic                  i_line_one_in,
	input  wire logic [15:0]           i_line_one_function,
	input  wire logic                  i_line_two_in,
	input  wire logic [15:0]           i_line_two_function,
	input  wire logic                  i_line_four_in,
	output logic                       o_line_four_out,
	output logic                       o_line_four_oe,
	// drive state
	input  wire logic                  i_power_enabled,
	input  wire logic                  i_local_mode,
	input  wire logic                  i_fault,
	input  wire logic                  i_drive_ready,
	input  wire logic                  i_homing_to_switch,
	input  wire logic [15:0]           i_profile_speed_ceiling,
	// requests to the drive
	output logic                       o_free_input,
	output logic                       o_halt_req,
	output logic                       o_fault_clear_req,
	output logic                       o_enable_req,
	// to the motion core
	output logic                       o_jog_pos,
	output logic                       o_jog_neg,
	output logic [15:0]                o_jog_speed,
	output logic                       o_neg_limit_hit,
	output logic                       o_pos_limit_hit,
	output logic                       o_home_switch_hit
);
	import djc_pkg::*;

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	typedef struct packed {
		logic [15:0]     home_pol;
		logic [15:0]     neg_pol;
		logic [15:0]     pos_pol;
		logic [15:0]     home_pol_act;
		logic [15:0]     neg_pol_act;
		logic [15:0]     pos_pol_act;
		logic [15:0]     line_func;
		logic [15:0]     line_func_act;
		logic [15:0]     soft_out;
		logic [15:0]     slow_speed;
		logic [15:0]     fast_speed;
		logic [15:0]     move_ctrl;
		logic            pwr_prev;
		djc_jog_state_t  jog;
		djc_par_rsp_t    rsp;
		djc_jog_cmd_t    cmd;
		djc_switch_hit_t hit;
		logic            line_out;
		logic            line_oe;
		logic            free_in;
		logic            halt;
		logic            fault_clr;
		logic            enable;
	} djc_state_t;

	djc_state_t st_r;
	djc_state_t st_nxt;

	// -------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------
	// triggered level of a switch for its evaluation setting
	function automatic logic switch_eval(input logic [15:0] pol, input logic raw);
		logic hit;
		hit = 1'b0;
		if (pol == DJC_POL_NC) begin
			hit = ~raw;
		end else if (pol == DJC_POL_NO) begin
			hit = raw;
		end
		return hit;
	endfunction

	function automatic logic [15:0] speed_min(input logic [15:0] a, input logic [15:0] b);
		return (a < b) ? a : b;
	endfunction

	function automatic logic speed_ok(input logic [15:0] v);
		return (v >= DJC_SPEED_MIN) && (v <= DJC_SPEED_MAX);
	endfunction

	function automatic logic line_func_ok(input logic [15:0] v);
		return (v == DJC_FN_IN_FREE) || (v == DJC_FN_IN_FLTCLR) ||
			(v == DJC_FN_IN_ENABLE) || (v == DJC_FN_IN_HALT) ||
			(v == DJC_FN_IN_JOG_POS) || (v == DJC_FN_IN_JOG_NEG) ||
			(v == DJC_FN_IN_JOG_FAST) || (v == DJC_FN_IN_HOME) ||
			(v == DJC_FN_OUT_FREE) || (v == DJC_FN_OUT_NOFAULT) ||
			(v == DJC_FN_OUT_READY);
	endfunction

	localparam djc_state_t ST_RESET = '{
		home_pol:      DJC_RST_POL,
		neg_pol:       DJC_RST_POL,
		pos_pol:       DJC_RST_POL,
		home_pol_act:  DJC_RST_POL,
		neg_pol_act:   DJC_RST_POL,
		pos_pol_act:   DJC_RST_POL,
		line_func:     LINE_FUNC_RESET,
		line_func_act: LINE_FUNC_RESET,
		soft_out:      16'h0000,
		slow_speed:    DJC_RST_SLOW_SPEED,
		fast_speed:    DJC_RST_FAST_SPEED,
		move_ctrl:     DJC_RST_MOVE_CTRL,
		pwr_prev:      1'b0,
		jog:           DJC_JOG_IDLE,
		rsp:           '0,
		cmd:           '0,
		hit:           '0,
		line_out:      1'b0,
		line_oe:       1'b0,
		free_in:       1'b0,
		halt:          1'b0,
		fault_clr:     1'b0,
		enable:        1'b0
	};

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb begin
		logic        is_in;
		logic [15:0] fn;
		logic        want_pos;
		logic        want_neg;
		logic        want_fast;
		logic        wr_ok;
		logic        hit_pos;
		logic [15:0] sel_speed;
		st_nxt = st_r;
		fn = st_r.line_func_act;
		is_in = i_line_four_in;
		wr_ok = 1'b0;
		want_pos = 1'b0;
		want_neg = 1'b0;
		want_fast = 1'b0;
		hit_pos = 1'b0;
		sel_speed = 16'h0000;

		// parameter access, answered one cycle after the request
		st_nxt.rsp = '0;
		if (i_par_req.wr) begin
			st_nxt.rsp.ack = 1'b1;
			if (i_par_req.addr == DJC_ADDR_HOME_POL) begin
				wr_ok = !i_power_enabled && (i_par_req.wdata == DJC_POL_NC ||
					i_par_req.wdata == DJC_POL_NO);
				if (wr_ok) begin
					st_nxt.home_pol = i_par_req.wdata;
				end
			end else if (i_par_req.addr == DJC_ADDR_NEG_POL) begin
				wr_ok = !i_power_enabled && (i_par_req.wdata <= DJC_POL_MAX);
				if (wr_ok) begin
					st_nxt.neg_pol = i_par_req.wdata;
				end
			end else if (i_par_req.addr == DJC_ADDR_POS_POL) begin
				wr_ok = !i_power_enabled && (i_par_req.wdata <= DJC_POL_MAX);
				if (wr_ok) begin
					st_nxt.pos_pol = i_par_req.wdata;
				end
			end else if (i_par_req.addr == DJC_ADDR_LINE_FUNC) begin
				wr_ok = !i_power_enabled && line_func_ok(i_par_req.wdata);
				if (wr_ok) begin
					st_nxt.line_func = i_par_req.wdata;
				end
			end else if (i_par_req.addr == DJC_ADDR_SOFT_OUT) begin
				wr_ok = 1'b1;
				st_nxt.soft_out = i_par_req.wdata;
			end else if (i_par_req.addr == DJC_ADDR_SLOW_SPEED) begin
				wr_ok = speed_ok(i_par_req.wdata);
				if (wr_ok) begin
					st_nxt.slow_speed = i_par_req.wdata;
				end
			end else if (i_par_req.addr == DJC_ADDR_FAST_SPEED) begin
				wr_ok = speed_ok(i_par_req.wdata);
				if (wr_ok) begin
					st_nxt.fast_speed = i_par_req.wdata;
				end
			end else if (i_par_req.addr == DJC_ADDR_MOVE_CTRL) begin
				wr_ok = (i_par_req.wdata <= DJC_MOVE_CTRL_MAX);
				if (wr_ok) begin
					st_nxt.move_ctrl = i_par_req.wdata;
				end
			end
			st_nxt.rsp.err = !wr_ok;
		end else if (i_par_req.rd) begin
			st_nxt.rsp.ack = 1'b1;
			if (i_par_req.addr == DJC_ADDR_HOME_POL) begin
				st_nxt.rsp.rdata = st_r.home_pol;
			end else if (i_par_req.addr == DJC_ADDR_NEG_POL) begin
				st_nxt.rsp.rdata = st_r.neg_pol;
			end else if (i_par_req.addr == DJC_ADDR_POS_POL) begin
				st_nxt.rsp.rdata = st_r.pos_pol;
			end else if (i_par_req.addr == DJC_ADDR_LINE_FUNC) begin
				st_nxt.rsp.rdata = st_r.line_func;
			end else if (i_par_req.addr == DJC_ADDR_SOFT_OUT) begin
				st_nxt.rsp.rdata = st_r.soft_out;
			end else if (i_par_req.addr == DJC_ADDR_SLOW_SPEED) begin
				st_nxt.rsp.rdata = st_r.slow_speed;
			end else if (i_par_req.addr == DJC_ADDR_FAST_SPEED) begin
				st_nxt.rsp.rdata = st_r.fast_speed;
			end else if (i_par_req.addr == DJC_ADDR_MOVE_CTRL) begin
				st_nxt.rsp.rdata = st_r.move_ctrl;
			end else if (i_par_req.addr == DJC_ADDR_STATUS) begin
				st_nxt.rsp.rdata = {9'h000, i_line_four_in, st_r.hit.home,
					st_r.hit.pos_limit, st_r.hit.neg_limit, 1'b0, st_r.jog};
			end else begin
				st_nxt.rsp.err = 1'b1;
			end
		end

		// switch settings take over on the rising edge of power stage enable
		st_nxt.pwr_prev = i_power_enabled;
		if (i_power_enabled && !st_r.pwr_prev) begin
			st_nxt.home_pol_act = st_r.home_pol;
			st_nxt.neg_pol_act = st_r.neg_pol;
			st_nxt.pos_pol_act = st_r.pos_pol;
		end

		// line four roles from the function fixed at reset by LINE_FUNC_RESET
		st_nxt.free_in = (fn == DJC_FN_IN_FREE) && is_in;
		st_nxt.halt = (fn == DJC_FN_IN_HALT) && is_in;
		st_nxt.fault_clr = (fn == DJC_FN_IN_FLTCLR) && is_in && i_local_mode;
		st_nxt.enable = (fn == DJC_FN_IN_ENABLE) && is_in && i_local_mode;
		st_nxt.line_oe = (fn == DJC_FN_OUT_FREE) || (fn == DJC_FN_OUT_NOFAULT) ||
			(fn == DJC_FN_OUT_READY);
		if (fn == DJC_FN_OUT_FREE) begin
			st_nxt.line_out = st_r.soft_out[DJC_SOFT_OUT_BIT];
		end else if (fn == DJC_FN_OUT_NOFAULT) begin
			st_nxt.line_out = !i_fault;
		end else if (fn == DJC_FN_OUT_READY) begin
			st_nxt.line_out = i_drive_ready;
		end else begin
			st_nxt.line_out = 1'b0;
		end

		// switch evaluation
		st_nxt.hit.neg_limit = (i_line_two_function == DJC_FN_IN_NEG_LIM) &&
			switch_eval(st_r.neg_pol_act, i_line_two_in);
		st_nxt.hit.pos_limit = (i_line_one_function == DJC_FN_IN_POS_LIM) &&
			switch_eval(st_r.pos_pol_act, i_line_one_in);
		st_nxt.hit.home = (fn == DJC_FN_IN_HOME) && i_homing_to_switch &&
			switch_eval(st_r.home_pol_act, is_in);

		// manual move requests from the control word and line four
		want_pos = st_r.move_ctrl[DJC_MC_POS_BIT] ||
			((fn == DJC_FN_IN_JOG_POS) && is_in);
		want_neg = st_r.move_ctrl[DJC_MC_NEG_BIT] ||
			((fn == DJC_FN_IN_JOG_NEG) && is_in);
		want_fast = st_r.move_ctrl[DJC_MC_FAST_BIT] ||
			((fn == DJC_FN_IN_JOG_FAST) && is_in);

		case (st_r.jog)
			DJC_JOG_IDLE: begin
				if (want_pos && !want_neg) begin
					st_nxt.jog = DJC_JOG_POS;
				end else if (want_neg && !want_pos) begin
					st_nxt.jog = DJC_JOG_NEG;
				end
			end
			DJC_JOG_POS: begin
				if (!want_pos && !want_neg) begin
					st_nxt.jog = DJC_JOG_IDLE;
				end else if (want_neg && !want_pos) begin
					st_nxt.jog = DJC_JOG_NEG;
				end
			end
			DJC_JOG_NEG: begin
				if (!want_pos && !want_neg) begin
					st_nxt.jog = DJC_JOG_IDLE;
				end else if (want_pos && !want_neg) begin
					st_nxt.jog = DJC_JOG_POS;
				end
			end
			default: begin
				st_nxt.jog = DJC_JOG_IDLE;
			end
		endcase

		hit_pos = (st_nxt.jog == DJC_JOG_POS);
		st_nxt.cmd.pos = hit_pos;
		st_nxt.cmd.neg = (st_nxt.jog == DJC_JOG_NEG);
		sel_speed = want_fast ? st_r.fast_speed : st_r.slow_speed;
		st_nxt.cmd.speed = (st_nxt.jog == DJC_JOG_IDLE) ? 16'h0000 :
			speed_min(sel_speed, i_profile_speed_ceiling);
	end

	// -------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// -------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------
	assign o_par_ack         = st_r.rsp.ack;
	assign o_par_err         = st_r.rsp.err;
	assign o_par_rdata       = st_r.rsp.rdata;
	assign o_line_four_out   = st_r.line_out;
	assign o_line_four_oe    = st_r.line_oe;
	assign o_free_input      = st_r.free_in;
	assign o_halt_req        = st_r.halt;
	assign o_fault_clear_req = st_r.fault_clr;
	assign o_enable_req      = st_r.enable;
	assign o_jog_pos         = st_r.cmd.pos;
	assign o_jog_neg         = st_r.cmd.neg;
	assign o_jog_speed       = st_r.cmd.speed;
	assign o_neg_limit_hit   = st_r.hit.neg_limit;
	assign o_pos_limit_hit   = st_r.hit.pos_limit;
	assign o_home_switch_hit = st_r.hit.home;

endmodule

// ==== design/djc_pkg.sv ====
// shared constants and types of the drive io, switch and manual move block
package djc_pkg;

	// -------------------------------------------------------------------
	// parameter addresses
	// -------------------------------------------------------------------
	localparam logic [15:0] DJC_ADDR_HOME_POL   = 16'h061c;
	localparam logic [15:0] DJC_ADDR_NEG_POL    = 16'h061e;
	localparam logic [15:0] DJC_ADDR_POS_POL    = 16'h0620;
	localparam logic [15:0] DJC_ADDR_LINE_FUNC  = 16'h0728;
	localparam logic [15:0] DJC_ADDR_SOFT_OUT   = 16'h0822;
	localparam logic [15:0] DJC_ADDR_SLOW_SPEED = 16'h2908;
	localparam logic [15:0] DJC_ADDR_FAST_SPEED = 16'h290a;
	localparam logic [15:0] DJC_ADDR_MOVE_CTRL  = 16'h2a00;
	localparam logic [15:0] DJC_ADDR_STATUS     = 16'h2a02;

	// -------------------------------------------------------------------
	// reset values and ranges
	// -------------------------------------------------------------------
	localparam logic [15:0] DJC_RST_POL        = 16'h0001;
	localparam logic [15:0] DJC_RST_LINE_FUNC  = 16'h0001;
	localparam logic [15:0] DJC_RST_SLOW_SPEED = 16'h003c;
	localparam logic [15:0] DJC_RST_FAST_SPEED = 16'h00b4;
	localparam logic [15:0] DJC_RST_MOVE_CTRL  = 16'h0000;
	localparam logic [15:0] DJC_SPEED_MIN      = 16'h0001;
	localparam logic [15:0] DJC_SPEED_MAX      = 16'h3390;
	localparam logic [15:0] DJC_MOVE_CTRL_MAX  = 16'h0007;
	localparam logic [15:0] DJC_POL_MAX        = 16'h0002;
	localparam int          DJC_SOFT_OUT_BIT   = 3;
	localparam int          DJC_MC_POS_BIT     = 0;
	localparam int          DJC_MC_NEG_BIT     = 1;
	localparam int          DJC_MC_FAST_BIT    = 2;

	// -------------------------------------------------------------------
	// switch evaluation settings and line function codes
	// -------------------------------------------------------------------
	localparam logic [15:0] DJC_POL_OFF        = 16'h0000;
	localparam logic [15:0] DJC_POL_NC         = 16'h0001;
	localparam logic [15:0] DJC_POL_NO         = 16'h0002;
	localparam logic [15:0] DJC_FN_IN_FREE     = 16'h0001;
	localparam logic [15:0] DJC_FN_IN_FLTCLR   = 16'h0002;
	localparam logic [15:0] DJC_FN_IN_ENABLE   = 16'h0003;
	localparam logic [15:0] DJC_FN_IN_HALT     = 16'h0004;
	localparam logic [15:0] DJC_FN_IN_JOG_POS  = 16'h0009;
	localparam logic [15:0] DJC_FN_IN_JOG_NEG  = 16'h000a;
	localparam logic [15:0] DJC_FN_IN_JOG_FAST = 16'h000b;
	localparam logic [15:0] DJC_FN_IN_HOME     = 16'h0014;
	localparam logic [15:0] DJC_FN_IN_POS_LIM  = 16'h0015;
	localparam logic [15:0] DJC_FN_IN_NEG_LIM  = 16'h0016;
	localparam logic [15:0] DJC_FN_OUT_FREE    = 16'h0065;
	localparam logic [15:0] DJC_FN_OUT_NOFAULT = 16'h0066;
	localparam logic [15:0] DJC_FN_OUT_READY   = 16'h0067;

	// -------------------------------------------------------------------
	// types
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		DJC_JOG_IDLE = 2'b00,
		DJC_JOG_POS  = 2'b01,
		DJC_JOG_NEG  = 2'b10
	} djc_jog_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} djc_par_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [15:0] rdata;
	} djc_par_rsp_t;

	typedef struct packed {
		logic        pos;
		logic        neg;
		logic [15:0] speed;
	} djc_jog_cmd_t;

	typedef struct packed {
		logic neg_limit;
		logic pos_limit;
		logic home;
	} djc_switch_hit_t;

endpackage

// ==== test/djc_checker.sv ====
// port assertions of the io line, switch and manual move block
`timescale 1ns/10ps
module djc_checker (
	// clock, reset and inputs
	input wire logic                  i_clock,
	input wire logic                  i_reset_n,
	input wire djc_pkg::djc_par_req_t i_par_req,
	input wire logic [15:0]           i_line_one_function,
	input wire logic [15:0]           i_line_two_function,
	input wire logic                  i_homing_to_switch,
	input wire logic [15:0]           i_profile_speed_ceiling,
	// outputs of the block
	input wire logic                  o_par_ack,
	input wire logic                  o_par_err,
	input wire logic [15:0]           o_par_rdata,
	input wire logic                  o_jog_pos,
	input wire logic                  o_jog_neg,
	input wire logic [15:0]           o_jog_speed,
	input wire logic                  o_neg_limit_hit,
	input wire logic                  o_pos_limit_hit,
	input wire logic                  o_home_switch_hit
);
	import djc_pkg::*;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	sequence s_req;
		i_par_req.wr || i_par_req.rd;
	endsequence
	sequence s_answer;
		o_par_ack;
	endsequence

	a_ack_follows: assert property (s_req |=> s_answer)
		else $error("request without answer one cycle later");
	a_ack_only_req: assert property (!(i_par_req.wr || i_par_req.rd) |=> !o_par_ack)
		else $error("answer without request");
	a_err_with_ack: assert property (o_par_err |-> o_par_ack)
		else $error("refusal flag outside an answer");
	a_write_rdata: assert property (i_par_req.wr |=> o_par_rdata == 16'h0000)
		else $error("read data not zero on a write answer");
	a_speed_clamp: assert property (o_jog_speed <= $past(i_profile_speed_ceiling))
		else $error("manual speed above the ceiling");
	a_idle_speed: assert property (!(o_jog_pos || o_jog_neg) |-> o_jog_speed == 16'h0000)
		else $error("speed given while idle");
	a_one_dir: assert property (!(o_jog_pos && o_jog_neg))
		else $error("both directions requested");
	a_home_gate: assert property (!$past(i_homing_to_switch) |-> !o_home_switch_hit)
		else $error("home switch acted outside homing");
	a_pos_route: assert property ($past(i_line_one_function) != DJC_FN_IN_POS_LIM
		|-> !o_pos_limit_hit)
		else $error("positive limit without its line function");
	a_neg_route: assert property ($past(i_line_two_function) != DJC_FN_IN_NEG_LIM
		|-> !o_neg_limit_hit)
		else $error("negative limit without its line function");
endmodule

bind djc_top djc_checker u_chk (
	.i_clock, .i_reset_n, .i_par_req, .i_line_one_function, .i_line_two_function,
	.i_homing_to_switch, .i_profile_speed_ceiling, .o_par_ack, .o_par_err, .o_par_rdata,
	.o_jog_pos, .o_jog_neg, .o_jog_speed, .o_neg_limit_hit, .o_pos_limit_hit,
	.o_home_switch_hit
);

// ==== test/djc_partner.sv ====
// parameter master and switch contacts outside the block
`timescale 1ns/10ps
module djc_partner (
	// clock and answer
	input  wire logic             i_clock,
	input  wire logic             i_par_err,
	input  wire logic [15:0]      i_par_rdata,
	// request and contacts
	output djc_pkg::djc_par_req_t o_par_req,
	output logic                  o_line_one_in,
	output logic                  o_line_two_in,
	output logic                  o_line_four_in
);
	import djc_pkg::*;
	initial begin
		o_par_req = '0;
		o_line_one_in = 1'b1;
		o_line_two_in = 1'b1;
		o_line_four_in = 1'b1;
	end
	// request held for one edge, answer read in the following cycle
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e);
		@(posedge i_clock);
		o_par_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge i_clock);
		o_par_req <= '0;
		@(negedge i_clock);
		e = i_par_err;
		q = i_par_rdata;
	endtask
	task automatic set_lines(input logic a, input logic b, input logic c);
		@(posedge i_clock);
		o_line_one_in <= a;
		o_line_two_in <= b;
		o_line_four_in <= c;
	endtask
endmodule

// ==== test/djc_top_tb.sv ====
// self-checking bench of the io line, switch and manual move block
`timescale 1ns/10ps
module djc_top_tb;
	import djc_pkg::*;
	logic         i_clock, i_reset_n, i_power_enabled, i_homing_to_switch;
	logic         i_local_mode, i_fault, i_drive_ready;
	logic [7:0]   x_out, x_oe, x_free, x_halt, x_fclr, x_en, x_jpos;
	logic         i_line_one_in, i_line_two_in, i_line_four_in;
	logic [15:0]  i_line_one_function, i_line_two_function, o_par_rdata, o_jog_speed;
	logic         o_par_ack, o_par_err, o_line_four_out, o_line_four_oe, o_free_input;
	logic         o_halt_req, o_fault_clear_req, o_enable_req, o_jog_pos, o_jog_neg;
	logic         o_neg_limit_hit, o_pos_limit_hit, o_home_switch_hit;
	djc_par_req_t i_par_req;
	int           mismatches = 0;
	int           samples_checked = 0;

	djc_top #(.LINE_FUNC_RESET(DJC_FN_IN_HOME)) dut (
		.i_clock, .i_reset_n, .i_par_req, .o_par_ack, .o_par_err, .o_par_rdata,
		.i_line_one_in, .i_line_one_function, .i_line_two_in, .i_line_two_function,
		.i_line_four_in, .o_line_four_out, .o_line_four_oe, .i_power_enabled,
		.i_local_mode, .i_fault, .i_drive_ready, .i_homing_to_switch,
		.i_profile_speed_ceiling(16'h03e8), .o_free_input, .o_halt_req,
		.o_fault_clear_req, .o_enable_req, .o_jog_pos, .o_jog_neg, .o_jog_speed,
		.o_neg_limit_hit, .o_pos_limit_hit, .o_home_switch_hit
	);
	djc_partner bfm (
		.i_clock, .i_par_err(o_par_err), .i_par_rdata(o_par_rdata), .o_par_req(i_par_req),
		.o_line_one_in(i_line_one_in), .o_line_two_in(i_line_two_in),
		.o_line_four_in(i_line_four_in)
	);

	// one more block for each of eight line four roles, since a role is fixed from reset by LINE_FUNC_RESET
	localparam logic [15:0] ROLE_CODE [8] = '{DJC_FN_IN_FREE, DJC_FN_IN_FLTCLR,
		DJC_FN_IN_ENABLE, DJC_FN_IN_HALT, DJC_FN_IN_JOG_POS, DJC_FN_OUT_FREE,
		DJC_FN_OUT_NOFAULT, DJC_FN_OUT_READY};
	for (genvar g = 0; g < 8; g++) begin : g_role
		djc_top #(.LINE_FUNC_RESET(ROLE_CODE[g])) dut (
			.i_clock, .i_reset_n, .i_par_req, .o_par_ack(), .o_par_err(), .o_par_rdata(),
			.i_line_one_in, .i_line_one_function, .i_line_two_in, .i_line_two_function,
			.i_line_four_in, .o_line_four_out(x_out[g]), .o_line_four_oe(x_oe[g]),
			.i_power_enabled, .i_local_mode, .i_fault, .i_drive_ready, .i_homing_to_switch,
			.i_profile_speed_ceiling(16'h03e8), .o_free_input(x_free[g]),
			.o_halt_req(x_halt[g]), .o_fault_clear_req(x_fclr[g]), .o_enable_req(x_en[g]),
			.o_jog_pos(x_jpos[g]), .o_jog_neg(), .o_jog_speed(), .o_neg_limit_hit(),
			.o_pos_limit_hit(), .o_home_switch_hit()
		);
	end

	// -------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [15:0] a, input logic [15:0] d, input logic e_exp);
		logic [15:0] q;
		logic        e;
		bfm.xfer(1'b1, a, d, q, e);
		chk({31'h0, e}, {31'h0, e_exp});
	endtask
	task automatic r(input logic [15:0] a, input logic [15:0] exp, input logic e_exp);
		logic [15:0] q;
		logic        e;
		bfm.xfer(1'b0, a, 16'h0000, q, e);
		chk({15'h0, e, q}, {15'h0, e_exp, exp});
	endtask
	task automatic jog(input logic [15:0] c, input logic p, input logic n, input logic [15:0] s);
		w(DJC_ADDR_MOVE_CTRL, c, 1'b0);
		repeat (2) @(negedge i_clock);
		chk({14'h0, o_jog_pos, o_jog_neg, o_jog_speed}, {14'h0, p, n, s});
	endtask
	task automatic hits(input logic [2:0] exp);
		repeat (3) @(negedge i_clock);
		chk({29'h0, o_neg_limit_hit, o_pos_limit_hit, o_home_switch_hit}, {29'h0, exp});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// -------------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------------
	task automatic roles(input logic [31:0] a, input logic [23:0] b);
		repeat (3) @(negedge i_clock);
		chk({x_free, x_fclr, x_en, x_halt}, a);
		chk({8'h00, x_jpos, x_oe, x_out}, {8'h00, b});
	endtask
	task automatic t_reset_vals();
		r(DJC_ADDR_HOME_POL, DJC_POL_NC, 1'b0);
		r(DJC_ADDR_NEG_POL, DJC_POL_NC, 1'b0);
		r(DJC_ADDR_POS_POL, DJC_POL_NC, 1'b0);
		r(DJC_ADDR_SLOW_SPEED, 16'h003c, 1'b0);
		r(DJC_ADDR_FAST_SPEED, 16'h00b4, 1'b0);
		r(DJC_ADDR_MOVE_CTRL, 16'h0000, 1'b0);
		r(DJC_ADDR_LINE_FUNC, DJC_FN_IN_HOME, 1'b0);
		r(16'h0100, 16'h0000, 1'b1);
		$display("test reset values done");
	endtask
	task automatic t_refusals();
		@(posedge i_clock) i_power_enabled <= 1'b1;
		w(DJC_ADDR_NEG_POL, DJC_POL_NO, 1'b1);
		w(DJC_ADDR_LINE_FUNC, DJC_FN_IN_HALT, 1'b1);
		@(posedge i_clock) i_power_enabled <= 1'b0;
		w(DJC_ADDR_NEG_POL, 16'h0003, 1'b1);
		w(DJC_ADDR_POS_POL, 16'h0003, 1'b1);
		w(DJC_ADDR_HOME_POL, DJC_POL_OFF, 1'b1);
		w(DJC_ADDR_MOVE_CTRL, 16'h0008, 1'b1);
		w(DJC_ADDR_SLOW_SPEED, 16'h0000, 1'b1);
		w(DJC_ADDR_FAST_SPEED, 16'h3391, 1'b1);
		w(DJC_ADDR_LINE_FUNC, DJC_FN_IN_HALT, 1'b0);
		r(DJC_ADDR_NEG_POL, DJC_POL_NC, 1'b0);
		bfm.set_lines(1'b1, 1'b1, 1'b1);
		repeat (3) @(negedge i_clock);
		chk({31'h0, o_halt_req}, 32'h0);
		$display("test refusals done");
	endtask
	task automatic t_switches();
		@(posedge i_clock);
		i_line_one_function <= DJC_FN_IN_POS_LIM;
		i_line_two_function <= DJC_FN_IN_NEG_LIM;
		bfm.set_lines(1'b0, 1'b1, 1'b0);
		hits(3'b010);
		w(DJC_ADDR_NEG_POL, DJC_POL_NO, 1'b0);
		w(DJC_ADDR_POS_POL, DJC_POL_OFF, 1'b0);
		w(DJC_ADDR_HOME_POL, DJC_POL_NO, 1'b0);
		hits(3'b010);
		@(posedge i_clock) i_power_enabled <= 1'b1;
		hits(3'b100);
		bfm.set_lines(1'b0, 1'b0, 1'b1);
		hits(3'b000);
		@(posedge i_clock) i_homing_to_switch <= 1'b1;
		hits(3'b001);
		@(posedge i_clock) i_line_two_function <= DJC_FN_IN_FREE;
		bfm.set_lines(1'b0, 1'b1, 1'b1);
		hits(3'b001);
		@(posedge i_clock);
		i_homing_to_switch <= 1'b0;
		i_power_enabled <= 1'b0;
		$display("test switches done");
	endtask
	task automatic t_roles();
		w(DJC_ADDR_SOFT_OUT, 16'h0008, 1'b0);
		@(posedge i_clock);
		i_local_mode <= 1'b1;
		i_drive_ready <= 1'b1;
		bfm.set_lines(1'b0, 1'b1, 1'b1);
		roles(32'h01020408, 24'h10e0e0);
		chk({26'h0, o_free_input, o_halt_req, o_fault_clear_req, o_enable_req,
			o_line_four_oe, o_line_four_out}, 32'h0);
		w(DJC_ADDR_SOFT_OUT, 16'h0000, 1'b0);
		@(posedge i_clock);
		i_local_mode <= 1'b0;
		i_fault <= 1'b1;
		i_drive_ready <= 1'b0;
		roles(32'h01000008, 24'h10e000);
		bfm.set_lines(1'b0, 1'b1, 1'b0);
		roles(32'h00000000, 24'h00e000);
		$display("test line roles done");
	endtask
	task automatic t_jog();
		jog(16'h0001, 1'b1, 1'b0, 16'h003c);
		w(DJC_ADDR_FAST_SPEED, 16'h3390, 1'b0);
		jog(16'h0005, 1'b1, 1'b0, 16'h03e8);
		jog(16'h0007, 1'b1, 1'b0, 16'h03e8);
		jog(16'h0006, 1'b0, 1'b1, 16'h03e8);
		jog(16'h0000, 1'b0, 1'b0, 16'h0000);
		jog(16'h0003, 1'b0, 1'b0, 16'h0000);
		w(DJC_ADDR_FAST_SPEED, 16'h00c8, 1'b0);
		jog(16'h0005, 1'b1, 1'b0, 16'h00c8);
		w(DJC_ADDR_SLOW_SPEED, 16'h0050, 1'b0);
		jog(16'h0001, 1'b1, 1'b0, 16'h0050);
		$display("test manual move done");
	endtask

	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	initial begin
		i_reset_n = 1'b0;
		i_power_enabled = 1'b0;
		i_homing_to_switch = 1'b0;
		i_local_mode = 1'b0;
		i_fault = 1'b0;
		i_drive_ready = 1'b0;
		i_line_one_function = DJC_FN_IN_FREE;
		i_line_two_function = DJC_FN_IN_FREE;
		repeat (4) @(posedge i_clock);
		i_reset_n <= 1'b1;
		t_reset_vals();
		t_refusals();
		t_switches();
		t_roles();
		t_jog();
		conclude();
	end
	// the tests need well under a thousand cycles
	initial begin
		repeat (3000) @(posedge i_clock);
		mismatches++;
		conclude();
	end
endmodule
